//--- dv/adcs_core_model.sv
// analog core model: answers the latest conversion start after a set latency
`timescale 1ns/1ps
module adcs_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // conversion request
  input wire logic start,
  input wire logic [3:0] ch,
  input wire logic [7:0] lat,
  // conversion answer
  output logic done,
  output logic [9:0] result
);
  logic busy;
  logic [3:0] cur;
  logic [7:0] cnt;
  // a new start drops the conversion in flight, so pre-emption restarts it
  // result lines toggle outside done so a stale value is never mistaken for data
  // conversion timing is counted on the system clock, so it never outpaces it
  always @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      result <= 10'h2aa;
    end else if (start) begin
      busy <= 1'b1;
      cur <= ch;
      cnt <= lat;
      done <= 1'b0;
      result <= ~result;
    end else if (busy && cnt <= 8'h01) begin
      busy <= 1'b0;
      done <= 1'b1;
      result <= {cur, 6'h11};
    end else begin
      cnt <= cnt - 8'h01;
      done <= 1'b0;
      result <= ~result;
    end
  end
endmodule : adcs_core_model

//--- dv/adcs_seq_bench.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module adcs_seq_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, last_err;
  logic trig = 1'b1, tm_n = 1'b0, tm_p = 1'b0;
  logic cs, cd, ref_en, irq_n, irq_p, irq_m0, irq_m1;
  logic [3:0] cch;
  logic [9:0] cres;
  logic [2:0] clk_sel;
  logic [7:0] lat = 8'h03;
  logic [3:0] chs [0:1023];
  int err_count = 0, cmp_count = 0;
  int n_st = 0, n_dn = 0, n_ni = 0, n_pi = 0, n_m0 = 0, n_m1 = 0;
  int s, d, i0, p0;

  adcs_seq adcs_seq_inst (.REF_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EXT_TRIGGER_PIN(trig), .TIMER_MATCH_NORMAL(tm_n),
    .TIMER_MATCH_PRIORITY(tm_p), .CONV_START(cs), .CONV_CHANNEL(cch), .CONV_DONE(cd),
    .CONV_RESULT(cres), .REFERENCE_ENABLE(ref_en), .CONVERSION_CLOCK_SELECT(clk_sel),
    .NORMAL_DONE_IRQ(irq_n), .PRIORITY_DONE_IRQ(irq_p), .MONITOR0_IRQ(irq_m0),
    .MONITOR1_IRQ(irq_m1));
  adcs_core_model adcs_core_model_inst (.clk(clk), .rst(rst), .start(cs), .ch(cch),
    .lat(lat), .done(cd), .result(cres));

  always #12.5 clk = ~clk;
  // pulses are counted on the falling edge, clear of the launching edge
  always @(negedge clk) begin
    if (cs === 1'b1) begin
      chs[n_st] = cch;
      n_st++;
    end
    if (cd === 1'b1) n_dn++;
    if (irq_n === 1'b1) n_ni++;
    if (irq_p === 1'b1) n_pi++;
    if (irq_m0 === 1'b1) n_m0++;
    if (irq_m1 === 1'b1) n_m1++;
  end

  function automatic logic [9:0] exp_res(input logic [3:0] c);
    return {c, 6'h11};
  endfunction : exp_res

  // whole aligned words only, so result registers never see a byte read
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(a, 1'b1, wd);
  endtask : wr

  task automatic rg(input logic [7:0] a);
    apb(a, 1'b0, 32'h0);
  endtask : rg

  task automatic wait_for(ref int c, input int t);
    for (int i = 0; i < 3000 && c < t; i++) @(posedge clk);
    `CHK(c >= t, 1'b1);
  endtask : wait_for

  task automatic wait_idle;
    for (int i = 0; i < 100; i++) begin
      rg(adcs_pkg::OFF_MODE0);
      if (rd[7] === 1'b0) break;
    end
  endtask : wait_idle

  task automatic run(input logic [31:0] m1, input logic [31:0] m0, input int k);
    s = n_st;
    d = n_dn;
    i0 = n_ni;
    wr(adcs_pkg::OFF_MODE1, m1);
    wr(adcs_pkg::OFF_MODE0, m0);
    wait_for(n_ni, i0 + k);
  endtask : run

  task automatic t_reset;
    rg(adcs_pkg::OFF_MODE0);
    `CHK(rd, 32'h0);
    rg(8'h1c);
    `CHK({last_err, rd}, 33'h100000000);
    wr(adcs_pkg::OFF_MODE1, 32'h80);
    // reference settles 3us, 120 cycles at 25 ns, before any start
    repeat (120) @(posedge clk);
    `CHK(ref_en, 1'b1);
    $display("reset test done");
  endtask : t_reset

  task automatic t_single;
    run(32'h85, 32'h01, 1);
    `CHK(chs[s], 4'h5);
    `CHK(n_dn - d, 1);
    rg(adcs_pkg::OFF_MODE0);
    `CHK(rd[7:6], 2'b01);
    rg(adcs_pkg::OFF_MODE0);
    `CHK(rd[6], 1'b0);
    rg(adcs_pkg::OFF_RES0);
    `CHK(rd[11:0], {2'b10, exp_res(4'h5)});
    $display("single test done");
  endtask : t_single

  task automatic t_scans;
    int last;
    for (int z = 0; z < 3; z++) begin
      last = (z + 1) * 4 - 1;
      run(32'h82 | (z << 4), 32'h03, 1);
      `CHK(n_dn - d, last + 1);
      `CHK(chs[s + last], 4'(2 + last));
      rg(adcs_pkg::OFF_RES0 + 8'(4 * last));
      `CHK(rd[9:0], exp_res(4'(2 + last)));
      rg(adcs_pkg::OFF_MODE0);
      `CHK(rd[7], 1'b0);
    end
    $display("scan test done");
  endtask : t_scans

  task automatic t_repeat;
    rg(adcs_pkg::OFF_RES0);
    run(32'h83, 32'h0d, 2);
    `CHK(n_dn - d, 8);
    rg(adcs_pkg::OFF_MODE0);
    `CHK(rd[7:6], 2'b11);
    wr(adcs_pkg::OFF_MODE0, 32'h0);
    wait_idle;
    `CHK(rd[7], 1'b0);
    rg(adcs_pkg::OFF_RES0);
    `CHK(rd[11:0], {2'b11, exp_res(4'h3)});
    // timing bit clear: every conversion reports
    run(32'h83, 32'h05, 2);
    `CHK(n_dn - d, 2);
    wr(adcs_pkg::OFF_MODE0, 32'h0);
    wait_idle;
    `CHK(rd[7], 1'b0);
    $display("repeat test done");
  endtask : t_repeat

  task automatic t_scan_rep;
    run(32'h80, 32'h07, 2);
    `CHK(n_dn - d, 8);
    rg(adcs_pkg::OFF_MODE0);
    `CHK(rd[7:6], 2'b11);
    wr(adcs_pkg::OFF_MODE0, 32'h02);
    wait_idle;
    `CHK((n_dn - d) % 4, 0);
    $display("scan repeat test done");
  endtask : t_scan_rep

  task automatic t_prio;
    lat <= 8'd40;
    s = n_st;
    i0 = n_ni;
    p0 = n_pi;
    wr(adcs_pkg::OFF_MODE1, 32'h83);
    wr(adcs_pkg::OFF_MODE0, 32'h01);
    wait_for(n_st, s + 1);
    wr(adcs_pkg::OFF_MODE2, 32'h1b);
    wr(adcs_pkg::OFF_MODE2, 32'h1b);
    wait_for(n_pi, p0 + 1);
    rg(adcs_pkg::OFF_MODE2);
    `CHK(rd[7:6], 2'b01);
    rg(adcs_pkg::OFF_MODE2);
    `CHK(rd[6], 1'b0);
    rg(adcs_pkg::OFF_RESP);
    `CHK(rd[9:0], exp_res(4'hb));
    wait_for(n_ni, i0 + 1);
    `CHK(n_st - s, 3);
    `CHK(chs[s + 1], 4'hb);
    `CHK(chs[s + 2], 4'h3);
    lat <= 8'h03;
    $display("priority test done");
  endtask : t_prio

  task automatic t_mon;
    int a, b;
    // thresholds go in while both monitors are still off
    wr(adcs_pkg::OFF_CMP0, 32'h100);
    wr(adcs_pkg::OFF_CMP1, 32'h100);
    wr(adcs_pkg::OFF_MODE3, 32'h42);
    wr(adcs_pkg::OFF_MODE5, 32'h02);
    a = n_m0;
    b = n_m1;
    run(32'h85, 32'h01, 1);
    repeat (3) @(posedge clk);
    `CHK(n_m0 - a, 1);
    `CHK(n_m1 - b, 0);
    run(32'h82, 32'h01, 1);
    repeat (3) @(posedge clk);
    `CHK(n_m0 - a, 1);
    `CHK(n_m1 - b, 1);
    wr(adcs_pkg::OFF_MODE3, 32'h0);
    wr(adcs_pkg::OFF_MODE5, 32'h0);
    $display("monitor test done");
  endtask : t_mon

  task automatic t_hw;
    wr(adcs_pkg::OFF_MODE0, 32'h0);
    wr(adcs_pkg::OFF_MODE1, 32'h84);
    // only the normal side listens to the pin
    wr(adcs_pkg::OFF_MODE4, 32'h02);
    s = n_st;
    i0 = n_ni;
    trig <= 1'b0;
    repeat (8) @(posedge clk);
    trig <= 1'b1;
    wait_for(n_ni, i0 + 1);
    repeat (10) @(posedge clk);
    `CHK(n_st - s, 1);
    `CHK(chs[s], 4'h4);
    wr(adcs_pkg::OFF_MODE4, 32'h03);
    i0 = n_ni;
    tm_n <= 1'b1;
    @(posedge clk);
    tm_n <= 1'b0;
    wait_for(n_ni, i0 + 1);
    wr(adcs_pkg::OFF_MODE4, 32'h0c);
    p0 = n_pi;
    tm_p <= 1'b1;
    @(posedge clk);
    tm_p <= 1'b0;
    wait_for(n_pi, p0 + 1);
    `CHK(chs[n_st - 1], 4'hb);
    // priority alone on the pin, normal hardware start kept off
    wr(adcs_pkg::OFF_MODE4, 32'h08);
    p0 = n_pi;
    trig <= 1'b0;
    repeat (8) @(posedge clk);
    trig <= 1'b1;
    wait_for(n_pi, p0 + 1);
    `CHK(chs[n_st - 1], 4'hb);
    wr(adcs_pkg::OFF_MODE4, 32'h0);
    $display("hardware start test done");
  endtask : t_hw

  task automatic t_srst;
    // clock select keeps its value through the soft reset, mode 1 does not
    wr(adcs_pkg::OFF_CLK, 32'h5);
    wr(adcs_pkg::OFF_MODE1, 32'h85);
    wr(adcs_pkg::OFF_MODE3, 32'h01);
    rg(adcs_pkg::OFF_CLK);
    `CHK(rd[2:0], 3'h5);
    rg(adcs_pkg::OFF_MODE1);
    `CHK(rd, 32'h0);
    `CHK({clk_sel, ref_en}, 4'ha);
    $display("soft reset test done");
  endtask : t_srst

  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_single;
    t_scans;
    t_repeat;
    t_scan_rep;
    t_prio;
    t_mon;
    t_hw;
    t_srst;
    end_sim;
  end

  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    end_sim;
  end
endmodule : adcs_seq_bench

//--- rtl/adcs_monitor.sv
// one threshold monitor watching a chosen result register
`timescale 1ns/1ps
module adcs_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration
  input wire logic en,
  input wire logic larger,
  input wire logic [3:0] sel,
  input wire logic [9:0] thr,
  // result store strobe
  input wire logic we,
  input wire logic [3:0] widx,
  input wire logic [9:0] wval,
  // event
  output logic irq
);
  logic irq_q;
  logic irq_d;

  always_comb begin
    irq_d = 1'b0;
    if (en && we && widx == sel) begin
      irq_d = larger ? (wval > thr) : (wval < thr);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign irq = irq_q;

  mon_hit_a: assert property (@(posedge clk) disable iff (rst)
    en && we && widx == sel && larger && wval > thr |=> irq)
    else $error("monitor missed a larger result");
endmodule : adcs_monitor

//--- rtl/adcs_pkg.sv
// package: register map, field layout and reset values of the conversion sequencer
package adcs_pkg;
  localparam logic [7:0] OFF_CLK = 8'h00;
  localparam logic [7:0] OFF_MODE0 = 8'h04;
  localparam logic [7:0] OFF_MODE1 = 8'h08;
  localparam logic [7:0] OFF_MODE2 = 8'h0c;
  localparam logic [7:0] OFF_MODE3 = 8'h10;
  localparam logic [7:0] OFF_MODE4 = 8'h14;
  localparam logic [7:0] OFF_MODE5 = 8'h18;
  localparam logic [7:0] OFF_RES0 = 8'h20;
  localparam logic [7:0] OFF_RES_LAST = 8'h4c;
  localparam logic [7:0] OFF_RESP = 8'h50;
  localparam logic [7:0] OFF_CMP0 = 8'h54;
  localparam logic [7:0] OFF_CMP1 = 8'h58;
  localparam int NRES = 12;
  // mode 0: scan, repeat, irq timing, done (read clears), busy
  localparam int M0_START = 0;
  localparam int M0_SCAN = 1;
  localparam int M0_TIMING = 3;
  localparam int M0_DONE = 6;
  // mode 1: channel select [3:0], scan size [5:4], reference enable [7]
  localparam int M1_CH = 0;
  localparam int M1_SIZE = 4;
  localparam int M1_REF = 7;
  localparam logic [7:0] M1_MASK = 8'hbf;
  // mode 2: priority channel [3:0], priority start [4], done [6], busy [7]
  localparam int M2_START = 4;
  localparam int M2_DONE = 6;
  // mode 3 / mode 5: [0] soft reset (mode 3 only), [1] enable, [5:2] select, [6] larger
  localparam int M3_RST = 0;
  localparam int MON_EN = 1;
  localparam int MON_SEL = 2;
  localparam int MON_COND = 6;
  localparam logic [6:0] MON_MASK = 7'h7e;
  // mode 4: normal source [0], normal hw enable [1], priority source [2], enable [3]
  localparam int M4_NSRC = 0;
  localparam int M4_NHW = 1;
  localparam int M4_PSRC = 2;
  localparam int M4_PHW = 3;
  // result word: value [9:0], overrun [10], stored [11]
  localparam int R_OVR = 10;
  localparam int R_STORED = 11;
  localparam logic [2:0] CLK_RST = 3'h0;
  localparam logic [1:0] SZ4 = 2'h0;
  localparam logic [1:0] SZ8 = 2'h1;
  localparam logic [3:0] LAST4 = 4'h3;
  localparam logic [3:0] LAST8 = 4'h7;
  localparam logic [3:0] LAST12 = 4'hb;
  localparam logic [1:0] TIMING_LAST = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_NORM, ST_PRIO} adcs_state_t;
endpackage : adcs_pkg

//--- rtl/adcs_seq.sv
// conversion sequencer: apb registers, normal and priority sequencing, result store
`timescale 1ns/1ps
module adcs_seq (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // hardware start sources
  input wire logic EXT_TRIGGER_PIN,
  input wire logic TIMER_MATCH_NORMAL,
  input wire logic TIMER_MATCH_PRIORITY,
  // analog core
  output logic CONV_START,
  output logic [3:0] CONV_CHANNEL,
  input wire logic CONV_DONE,
  input wire logic [9:0] CONV_RESULT,
  output logic REFERENCE_ENABLE,
  output logic [2:0] CONVERSION_CLOCK_SELECT,
  // completion events
  output logic NORMAL_DONE_IRQ,
  output logic PRIORITY_DONE_IRQ,
  output logic MONITOR0_IRQ,
  output logic MONITOR1_IRQ
);
  logic setup, acc, wr, rd, swrst, rst, hit, rhit;
  logic [7:0] roff;
  logic [3:0] ridx;
  logic [31:0] rdata;
  logic [31:0] prdata_q;
  logic [2:0] clk_q, clk_d;
  logic [2:0] m0_q, m0_d;
  logic [7:0] m1_q, m1_d;
  logic [3:0] m2_q, m2_d;
  logic [6:0] m3_q, m3_d, m5_q, m5_d;
  logic [3:0] m4_q, m4_d;
  logic [9:0] cmp_q [0:1];
  logic [9:0] cmp_d [0:1];
  logic trig_s1_q, trig_s2_q, trig_s3_q, trig_fall;
  logic nstart, pstart;
  adcs_pkg::adcs_state_t st_q, st_d;
  logic nbusy_q, nbusy_d, pbusy_q, pbusy_d, ndone_q, ndone_d, pdone_q, pdone_d;
  logic [3:0] pos_q, pos_d, scan_last, norm_ch, chan_q, chan_d;
  logic [1:0] ring_q, ring_d;
  logic start_q, start_d, nirq_q, nirq_d, pirq_q, pirq_d;
  logic scan, rep, evt, res_we, pres_we;
  logic [3:0] res_idx;
  logic [9:0] res_q [0:adcs_pkg::NRES-1];
  logic [9:0] res_d [0:adcs_pkg::NRES-1];
  logic [adcs_pkg::NRES-1:0] stored_q, stored_d, ovr_q, ovr_d;
  logic [9:0] resp_q, resp_d;

  // apb decode; every transfer finishes in its first access cycle
  assign setup = PSEL && !PENABLE;
  assign acc = PSEL && PENABLE;
  assign wr = acc && PWRITE;
  assign rd = acc && !PWRITE;
  assign swrst = wr && PADDR == adcs_pkg::OFF_MODE3 && PWDATA[adcs_pkg::M3_RST];
  assign rst = SYS_RST || swrst;
  assign roff = PADDR - adcs_pkg::OFF_RES0;
  assign ridx = roff[5:2];
  assign rhit = PADDR >= adcs_pkg::OFF_RES0 && PADDR <= adcs_pkg::OFF_RES_LAST
    && PADDR[1:0] == 2'b00;
  assign PREADY = 1'b1;
  assign PSLVERR = acc && !hit;
  assign PRDATA = prdata_q;

  // read view, captured in the setup cycle so read-clear only drops what was seen
  always_comb begin
    rdata = 32'h0;
    hit = 1'b1;
    case (PADDR)
      adcs_pkg::OFF_CLK: rdata[2:0] = clk_q;
      adcs_pkg::OFF_MODE0: rdata[7:0] = {nbusy_q, ndone_q, 2'b00, m0_q, 1'b0};
      adcs_pkg::OFF_MODE1: rdata[7:0] = m1_q;
      adcs_pkg::OFF_MODE2: rdata[7:0] = {pbusy_q, pdone_q, 2'b00, m2_q};
      adcs_pkg::OFF_MODE3: rdata[6:0] = m3_q;
      adcs_pkg::OFF_MODE4: rdata[3:0] = m4_q;
      adcs_pkg::OFF_MODE5: rdata[6:0] = m5_q;
      adcs_pkg::OFF_RESP: rdata[9:0] = resp_q;
      adcs_pkg::OFF_CMP0: rdata[9:0] = cmp_q[0];
      adcs_pkg::OFF_CMP1: rdata[9:0] = cmp_q[1];
      default: begin
        if (rhit) begin
          rdata[11:0] = {stored_q[ridx], ovr_q[ridx], res_q[ridx]};
        end else begin
          hit = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (rst) begin
      prdata_q <= 32'h0;
    end else if (setup) begin
      prdata_q <= rdata;
    end
  end

  // configuration registers
  always_comb begin
    clk_d = clk_q;
    m0_d = m0_q;
    m1_d = m1_q;
    m2_d = m2_q;
    m3_d = m3_q;
    m4_d = m4_q;
    m5_d = m5_q;
    cmp_d = cmp_q;
    if (wr) begin
      case (PADDR)
        adcs_pkg::OFF_CLK: clk_d = PWDATA[2:0];
        adcs_pkg::OFF_MODE0: m0_d = PWDATA[adcs_pkg::M0_TIMING:adcs_pkg::M0_SCAN];
        adcs_pkg::OFF_MODE1: m1_d = PWDATA[7:0] & adcs_pkg::M1_MASK;
        adcs_pkg::OFF_MODE2: m2_d = PWDATA[3:0];
        adcs_pkg::OFF_MODE3: m3_d = PWDATA[6:0] & adcs_pkg::MON_MASK;
        adcs_pkg::OFF_MODE4: m4_d = PWDATA[3:0];
        adcs_pkg::OFF_MODE5: m5_d = PWDATA[6:0] & adcs_pkg::MON_MASK;
        // threshold writes are taken as-is; software keeps the monitor off meanwhile
        adcs_pkg::OFF_CMP0: cmp_d[0] = PWDATA[9:0];
        adcs_pkg::OFF_CMP1: cmp_d[1] = PWDATA[9:0];
        default: clk_d = clk_q;
      endcase
    end
  end

  // clock select survives the soft reset, so only the system reset touches it
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      clk_q <= adcs_pkg::CLK_RST;
    end else begin
      clk_q <= clk_d;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (rst) begin
      m0_q <= 3'h0;
      m1_q <= 8'h0;
      m2_q <= 4'h0;
      m3_q <= 7'h0;
      m4_q <= 4'h0;
      m5_q <= 7'h0;
      cmp_q <= '{10'h0, 10'h0};
    end else begin
      m0_q <= m0_d;
      m1_q <= m1_d;
      m2_q <= m2_d;
      m3_q <= m3_d;
      m4_q <= m4_d;
      m5_q <= m5_d;
      cmp_q <= cmp_d;
    end
  end

  // reference and clock select only drive the analog core; their timing is software's
  assign REFERENCE_ENABLE = m1_q[adcs_pkg::M1_REF];
  assign CONVERSION_CLOCK_SELECT = clk_q;

  // trigger pin: three-stage synchroniser, edge taken from the settled stages
  always_ff @(posedge REF_CLK) begin
    if (rst) begin
      trig_s1_q <= 1'b1;
      trig_s2_q <= 1'b1;
      trig_s3_q <= 1'b1;
    end else begin
      trig_s1_q <= EXT_TRIGGER_PIN;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  assign trig_fall = trig_s3_q && !trig_s2_q;

  // software start needs no enable and is ignored while that side is busy; hardware start only when its enable is set
  assign nstart = (wr && PADDR == adcs_pkg::OFF_MODE0 && PWDATA[adcs_pkg::M0_START])
    || (m4_q[adcs_pkg::M4_NHW] && (m4_q[adcs_pkg::M4_NSRC] ? TIMER_MATCH_NORMAL
    : trig_fall));
  assign pstart = (wr && PADDR == adcs_pkg::OFF_MODE2 && PWDATA[adcs_pkg::M2_START])
    || (m4_q[adcs_pkg::M4_PHW] && (m4_q[adcs_pkg::M4_PSRC] ? TIMER_MATCH_PRIORITY
    : trig_fall));

  assign scan = m0_q[0];
  assign rep = m0_q[1];
  assign scan_last = m1_q[5:4] == adcs_pkg::SZ4 ? adcs_pkg::LAST4
    : m1_q[5:4] == adcs_pkg::SZ8 ? adcs_pkg::LAST8 : adcs_pkg::LAST12;
  assign norm_ch = scan ? m1_q[3:0] + pos_q : m1_q[3:0];

  // sequencer
  always_comb begin
    st_d = st_q;
    nbusy_d = nbusy_q;
    pbusy_d = pbusy_q;
    pos_d = pos_q;
    ring_d = ring_q;
    start_d = 1'b0;
    chan_d = chan_q;
    evt = 1'b0;
    res_we = 1'b0;
    res_idx = 4'h0;
    pres_we = 1'b0;
    if (nstart && !nbusy_q) begin
      nbusy_d = 1'b1;
      pos_d = 4'h0;
      ring_d = 2'h0;
    end
    if (pstart && !pbusy_q) begin
      pbusy_d = 1'b1;
    end
    case (st_q)
      adcs_pkg::ST_IDLE: begin
        if (pbusy_q) begin
          start_d = 1'b1;
          chan_d = m2_q;
          st_d = adcs_pkg::ST_PRIO;
        end else if (nbusy_q) begin
          start_d = 1'b1;
          chan_d = norm_ch;
          st_d = adcs_pkg::ST_NORM;
        end
      end
      adcs_pkg::ST_NORM: begin
        if (CONV_DONE) begin
          res_we = 1'b1;
          st_d = adcs_pkg::ST_IDLE;
          if (scan) begin
            res_idx = pos_q;
            pos_d = pos_q == scan_last ? 4'h0 : pos_q + 4'h1;
            evt = pos_q == scan_last;
          end else begin
            res_idx = rep ? {2'b00, ring_q} : 4'h0;
            ring_d = ring_q + 2'h1;
            evt = !rep || !m0_q[2] || ring_q == adcs_pkg::TIMING_LAST;
          end
          // clearing repeat ends the sequence at the next natural end point
          if (!rep && evt) begin
            nbusy_d = 1'b0;
          end
        end else if (pbusy_q) begin
          start_d = 1'b1;
          chan_d = m2_q;
          st_d = adcs_pkg::ST_PRIO;
        end
      end
      adcs_pkg::ST_PRIO: begin
        if (CONV_DONE) begin
          pres_we = 1'b1;
          pbusy_d = 1'b0;
          st_d = adcs_pkg::ST_IDLE;
        end
      end
      default: st_d = adcs_pkg::ST_IDLE;
    endcase
    nirq_d = evt;
    pirq_d = pres_we;
    // set wins over the read-clear in the same cycle
    ndone_d = evt || (ndone_q && !(rd && PADDR == adcs_pkg::OFF_MODE0
      && prdata_q[adcs_pkg::M0_DONE]));
    pdone_d = pres_we || (pdone_q && !(rd && PADDR == adcs_pkg::OFF_MODE2
      && prdata_q[adcs_pkg::M2_DONE]));
  end

  always_ff @(posedge REF_CLK) begin
    if (rst) begin
      st_q <= adcs_pkg::ST_IDLE;
      nbusy_q <= 1'b0;
      pbusy_q <= 1'b0;
      ndone_q <= 1'b0;
      pdone_q <= 1'b0;
      pos_q <= 4'h0;
      ring_q <= 2'h0;
      start_q <= 1'b0;
      chan_q <= 4'h0;
      nirq_q <= 1'b0;
      pirq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      nbusy_q <= nbusy_d;
      pbusy_q <= pbusy_d;
      ndone_q <= ndone_d;
      pdone_q <= pdone_d;
      pos_q <= pos_d;
      ring_q <= ring_d;
      start_q <= start_d;
      chan_q <= chan_d;
      nirq_q <= nirq_d;
      pirq_q <= pirq_d;
    end
  end

  assign CONV_START = start_q;
  assign CONV_CHANNEL = chan_q;
  assign NORMAL_DONE_IRQ = nirq_q;
  assign PRIORITY_DONE_IRQ = pirq_q;

  // result store with stored and overrun flags
  always_comb begin
    res_d = res_q;
    stored_d = stored_q;
    ovr_d = ovr_q;
    resp_d = pres_we ? CONV_RESULT : resp_q;
    if (rd && rhit) begin
      stored_d[ridx] = stored_q[ridx] && !prdata_q[adcs_pkg::R_STORED];
      ovr_d[ridx] = ovr_q[ridx] && !prdata_q[adcs_pkg::R_OVR];
    end
    if (res_we) begin
      res_d[res_idx] = CONV_RESULT;
      ovr_d[res_idx] = stored_q[res_idx] || ovr_d[res_idx];
      stored_d[res_idx] = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (rst) begin
      res_q <= '{default: 10'h0};
      stored_q <= '0;
      ovr_q <= '0;
      resp_q <= 10'h0;
    end else begin
      res_q <= res_d;
      stored_q <= stored_d;
      ovr_q <= ovr_d;
      resp_q <= resp_d;
    end
  end

  // two identical monitors, each on its own configuration register
  adcs_monitor u_mon0 (
    .clk(REF_CLK),
    .rst(rst),
    .en(m3_q[adcs_pkg::MON_EN]),
    .larger(m3_q[adcs_pkg::MON_COND]),
    .sel(m3_q[adcs_pkg::MON_SEL +: 4]),
    .thr(cmp_q[0]),
    .we(res_we),
    .widx(res_idx),
    .wval(CONV_RESULT),
    .irq(MONITOR0_IRQ)
  );

  adcs_monitor u_mon1 (
    .clk(REF_CLK),
    .rst(rst),
    .en(m5_q[adcs_pkg::MON_EN]),
    .larger(m5_q[adcs_pkg::MON_COND]),
    .sel(m5_q[adcs_pkg::MON_SEL +: 4]),
    .thr(cmp_q[1]),
    .we(res_we),
    .widx(res_idx),
    .wval(CONV_RESULT),
    .irq(MONITOR1_IRQ)
  );

  single_end_a: assert property (@(posedge REF_CLK) disable iff (rst)
    st_q == adcs_pkg::ST_NORM && CONV_DONE && !scan && !rep
    |=> !nbusy_q && ndone_q && NORMAL_DONE_IRQ)
    else $error("single conversion did not complete cleanly");
  scan_mid_a: assert property (@(posedge REF_CLK) disable iff (rst)
    st_q == adcs_pkg::ST_NORM && CONV_DONE && scan && pos_q != scan_last
    |=> !NORMAL_DONE_IRQ && nbusy_q && pos_q == $past(pos_q) + 4'h1)
    else $error("scan ended early");
  repeat_busy_a: assert property (@(posedge REF_CLK) disable iff (rst)
    st_q == adcs_pkg::ST_NORM && CONV_DONE && rep |=> nbusy_q)
    else $error("busy dropped in repeat mode");
  preempt_a: assert property (@(posedge REF_CLK) disable iff (rst)
    st_q == adcs_pkg::ST_NORM && pbusy_q && !CONV_DONE
    |=> CONV_START && CONV_CHANNEL == $past(m2_q))
    else $error("priority request did not pre-empt");
  prio_done_a: assert property (@(posedge REF_CLK) disable iff (rst)
    st_q == adcs_pkg::ST_PRIO && CONV_DONE |=> pdone_q && !pbusy_q && PRIORITY_DONE_IRQ)
    else $error("priority completion flags wrong");
  prio_ignore_a: assert property (@(posedge REF_CLK) disable iff (rst)
    pbusy_q && !(st_q == adcs_pkg::ST_PRIO && CONV_DONE) |=> pbusy_q && $stable(resp_q))
    else $error("priority request disturbed running priority");
  resume_a: assert property (@(posedge REF_CLK) disable iff (rst)
    st_q == adcs_pkg::ST_PRIO && CONV_DONE && nbusy_q |=> $stable(pos_q) ##1 CONV_START)
    else $error("normal sequence did not resume");
  overrun_a: assert property (@(posedge REF_CLK) disable iff (rst)
    res_we && stored_q[res_idx] |=> ovr_q[$past(res_idx)] && stored_q[$past(res_idx)])
    else $error("overrun not flagged");
  trig_once_a: assert property (@(posedge REF_CLK) disable iff (rst)
    trig_fall |=> !trig_fall)
    else $error("trigger edge gave two starts");
  soft_rst_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    swrst |=> clk_q == $past(clk_q) && !nbusy_q && m1_q == 8'h0)
    else $error("soft reset handled clock select wrong");
endmodule : adcs_seq
